/* swdp_pkg.sv */
package swdp_pkg;

  // ----------------------------------------------------------------
  // Debug clock divider
  // ----------------------------------------------------------------
  // One debug clock tick every eight ref_clk cycles (15.625 MHz)
  localparam logic [2:0] DIV_LAST = 3'h7;

  // ----------------------------------------------------------------
  // Bit and sync timing, in debug clock ticks; MEAS_MAX in ref_clk cycles
  // ----------------------------------------------------------------
  localparam logic [7:0] T_ONE_LOW = 8'h04;
  localparam logic [7:0] T_ONE_SPEED = 8'h05;
  localparam logic [7:0] T_SAMPLE = 8'h0a;
  localparam logic [7:0] T_ZERO_LOW = 8'h0d;
  localparam logic [7:0] T_TX_END = 8'h0f;
  localparam logic [7:0] T_HOST_BIT = 8'h14;
  localparam logic [7:0] T_SPEED = 8'h01;
  localparam logic [7:0] T_SYNC_DET = 8'h40;
  localparam logic [7:0] T_SYNC_REQ = 8'h80;
  localparam logic [7:0] T_SYNC_WAIT = 8'h10;
  localparam logic [7:0] T_SYNC_RESP = 8'h80;
  localparam logic [7:0] T_SYNC_TMO = 8'hff;
  localparam logic [11:0] MEAS_MAX = 12'hfff;

  // ----------------------------------------------------------------
  // Frame lengths
  // ----------------------------------------------------------------
  localparam logic [4:0] BYTE_LAST = 5'h07;
  localparam logic [4:0] ADDR_LAST = 5'h0f;
  localparam logic [5:0] BITS_BYTE = 6'h08;
  localparam logic [5:0] BITS_ADDR = 6'h10;

  // ----------------------------------------------------------------
  // Commands and status layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_STATUS = 8'h01;
  localparam logic [7:0] CMD_WRITE_CONTROL = 8'h02;
  localparam logic [7:0] CMD_READ_MEM = 8'h03;
  localparam logic [7:0] CMD_WRITE_MEM = 8'h04;
  localparam logic [7:0] CMD_BACKGROUND = 8'h05;
  localparam logic [7:0] CMD_GO = 8'h06;
  localparam int ST_BDM_BIT = 7;
  localparam int ST_RST_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  typedef struct packed {
    logic addr;
    logic wdata;
    logic rdata;
  } swdp_fmt_t;

  // Which fields follow a command byte
  function automatic swdp_fmt_t swdp_cmd_fmt(input logic [7:0] cmd);
    swdp_fmt_t f;
    f = '{addr: 1'b0, wdata: 1'b0, rdata: 1'b0};
    case (cmd)
      CMD_READ_STATUS: f.rdata = 1'b1;
      CMD_WRITE_CONTROL: f.wdata = 1'b1;
      CMD_READ_MEM: begin
        f.addr = 1'b1;
        f.rdata = 1'b1;
      end
      CMD_WRITE_MEM: begin
        f.addr = 1'b1;
        f.wdata = 1'b1;
      end
      default: f.addr = 1'b0;
    endcase
    return f;
  endfunction

endpackage

/* swdp_link_if.sv */
`timescale 1ns/1ps
interface swdp_link_if;
  logic host_out;
  logic host_oe;
  logic dev_out;
  logic dev_oe;
  logic rst_oe;
  logic debug_pin;
  logic reset_n;

  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  // shared single pin
  assign debug_pin = host_oe ? host_out : (dev_oe ? dev_out : 1'b1);
  assign reset_n = ~rst_oe;

  modport dev (input debug_pin, input reset_n, output dev_out, output dev_oe);
  modport host (input debug_pin, input reset_n, output host_out, output host_oe,
    output rst_oe);
endinterface

/* swdp_target.sv */
// Overview of operation
// - One pin carries commands and data both ways.
// - Host starts every bit; target never does.
// - Host falling edge begins each bit.
// - Commands and data travel MSB first.
// - Host times bits from target debug clock.
// - Sync request answered with timed low pulse.
// - Pin level at reset selects debug mode.
// - Pseudo-open-drain pin with internal pullup.
// - Brief driven-high speedup pulses, never conflicting.
// - Non-intrusive commands never halt the processor.
// - Commands access memory and debug registers.
// - Host resets target only by pulling low.
`timescale 1ns/1ps
module swdp_target import swdp_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Debug link
  swdp_link_if.dev link,
  // Memory access port
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  input wire logic [7:0] mem_rdata,
  // Chip control
  output logic [7:0] debug_ctrl,
  output logic bdm_active,
  output logic chip_reset_n
);

  typedef enum {B_IDLE, B_RX, B_TX, B_SYNC_LOW, B_SYNC_WAIT, B_SYNC_DRIVE,
    B_SYNC_SPEED} swdp_bit_t;
  typedef enum {P_CMD, P_ADDR, P_DATA, P_EXEC, P_READ, P_SEND} swdp_phase_t;
  logic [2:0] div_reg;
  logic tick_reg, pin_s1, pin_s2, pin_d, rst_s1, rst_s2;
  logic strap_reg, bdm_reg, chip_reset_n_reg, dev_oe_reg, dev_out_reg, mem_we_reg, mem_re_reg;
  logic [7:0] ctrl_reg, tcnt_reg, lim, cmd_reg, wdata_reg, tx_sr_reg, status;
  logic [4:0] bcnt_reg;
  logic [15:0] addr_reg;
  swdp_bit_t bst_reg;
  swdp_phase_t phase_reg;
  logic pin_fall, rx_bit, tx_done, sync_hit, cnt_done, exec;
  swdp_fmt_t cmd_fmt, new_fmt;
  // ----------------------------------------------------------------
  // Debug clock and input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= 3'h0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (div_reg == DIV_LAST);
      div_reg <= div_reg + 3'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_d <= 1'b1;
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      pin_s1 <= link.debug_pin;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
      rst_s1 <= link.reset_n;
      rst_s2 <= rst_s1;
    end
  end
  // bit begins at host falling edge
  assign pin_fall = pin_d & ~pin_s2;
  assign rx_bit = (bst_reg == B_RX) && tick_reg && (tcnt_reg == T_SAMPLE);
  assign tx_done = (bst_reg == B_TX) && tick_reg && (tcnt_reg == T_TX_END);
  assign sync_hit = (bst_reg == B_RX) && tick_reg && (tcnt_reg == T_SYNC_DET) && !pin_s2;
  assign exec = (phase_reg == P_EXEC);
  assign cmd_fmt = swdp_cmd_fmt(cmd_reg);
  assign new_fmt = swdp_cmd_fmt({cmd_reg[6:0], pin_s2});
  // ----------------------------------------------------------------
  // Reset strap, mode and control
  // ----------------------------------------------------------------
  // Strap is caught by the clock while reset is held, never by the async reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      chip_reset_n_reg <= 1'b0;
      strap_reg <= 1'b1;
      bdm_reg <= 1'b0;
      ctrl_reg <= CTRL_RESET;
    end else begin
      chip_reset_n_reg <= rst_s2;
      if (!rst_s2) begin
        strap_reg <= pin_s2;
      end
      if (rst_s2 && !chip_reset_n_reg) begin
        bdm_reg <= ~strap_reg;
      end else if (exec && cmd_reg == CMD_BACKGROUND) begin
        bdm_reg <= 1'b1;
      end else if (exec && cmd_reg == CMD_GO) begin
        bdm_reg <= 1'b0;
      end
      if (exec && cmd_reg == CMD_WRITE_CONTROL) begin
        ctrl_reg <= wdata_reg;
      end
    end
  end
  always_comb begin
    status = ctrl_reg;
    status[ST_BDM_BIT] = bdm_reg;
    status[ST_RST_BIT] = ~chip_reset_n_reg;
  end
  // ----------------------------------------------------------------
  // Bit engine
  // ----------------------------------------------------------------
  assign lim = (bst_reg == B_SYNC_WAIT) ? T_SYNC_WAIT :
    ((bst_reg == B_SYNC_DRIVE) ? T_SYNC_RESP : T_SPEED);
  assign cnt_done = tick_reg && (tcnt_reg == lim - 8'h01);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bst_reg <= B_IDLE;
      tcnt_reg <= 8'h00;
    end else begin
      unique case (bst_reg)
        // only a host edge starts a bit
        B_IDLE: if (pin_fall) begin
          tcnt_reg <= 8'h00;
          bst_reg <= (phase_reg == P_SEND) ? B_TX : B_RX;
        end
        B_RX: if (sync_hit) begin
          bst_reg <= B_SYNC_LOW;
        end else if (pin_s2 && tcnt_reg > T_SAMPLE) begin
          bst_reg <= B_IDLE;
        end else if (tick_reg) begin
          tcnt_reg <= tcnt_reg + 8'h01;
        end
        B_TX: if (tx_done) begin
          bst_reg <= B_IDLE;
        end else if (tick_reg) begin
          tcnt_reg <= tcnt_reg + 8'h01;
        end
        B_SYNC_LOW: if (pin_s2) begin
          tcnt_reg <= 8'h00;
          bst_reg <= B_SYNC_WAIT;
        end
        B_SYNC_WAIT, B_SYNC_DRIVE, B_SYNC_SPEED: if (cnt_done) begin
          tcnt_reg <= 8'h00;
          bst_reg <= (bst_reg == B_SYNC_WAIT) ? B_SYNC_DRIVE :
            (bst_reg == B_SYNC_DRIVE) ? B_SYNC_SPEED : B_IDLE;
        end else if (tick_reg) begin
          tcnt_reg <= tcnt_reg + 8'h01;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // drive high one tick only, pullup does the rest
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dev_oe_reg <= 1'b0;
      dev_out_reg <= 1'b1;
    end else begin
      dev_oe_reg <= 1'b0;
      dev_out_reg <= 1'b1;
      unique case (bst_reg)
        B_TX: if (!tx_sr_reg[7]) begin
          dev_oe_reg <= (tcnt_reg >= T_ONE_SPEED) && (tcnt_reg <= T_ZERO_LOW);
          dev_out_reg <= (tcnt_reg == T_ZERO_LOW);
        end else begin
          dev_oe_reg <= (tcnt_reg == T_ONE_SPEED);
        end
        B_SYNC_DRIVE: begin
          dev_oe_reg <= 1'b1;
          dev_out_reg <= 1'b0;
        end
        B_SYNC_SPEED: dev_oe_reg <= 1'b1;
        B_IDLE, B_RX, B_SYNC_LOW, B_SYNC_WAIT: dev_oe_reg <= 1'b0;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Command layer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= P_CMD;
      bcnt_reg <= 5'h00;
      cmd_reg <= 8'h00;
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
      tx_sr_reg <= 8'h00;
      mem_we_reg <= 1'b0;
      mem_re_reg <= 1'b0;
    end else begin
      mem_we_reg <= 1'b0;
      mem_re_reg <= 1'b0;
      // Sync aborts any half-received frame
      if (sync_hit) begin
        phase_reg <= P_CMD;
        bcnt_reg <= 5'h00;
      end else begin
        unique case (phase_reg)
          P_CMD: if (rx_bit) begin
            cmd_reg <= {cmd_reg[6:0], pin_s2};
            bcnt_reg <= (bcnt_reg == BYTE_LAST) ? 5'h00 : bcnt_reg + 5'h01;
            if (bcnt_reg == BYTE_LAST) begin
              phase_reg <= new_fmt.addr ? P_ADDR : (new_fmt.wdata ? P_DATA : P_EXEC);
            end
          end
          P_ADDR: if (rx_bit) begin
            addr_reg <= {addr_reg[14:0], pin_s2};
            bcnt_reg <= (bcnt_reg == ADDR_LAST) ? 5'h00 : bcnt_reg + 5'h01;
            if (bcnt_reg == ADDR_LAST) begin
              phase_reg <= cmd_fmt.wdata ? P_DATA : P_EXEC;
            end
          end
          P_DATA: if (rx_bit) begin
            wdata_reg <= {wdata_reg[6:0], pin_s2};
            bcnt_reg <= (bcnt_reg == BYTE_LAST) ? 5'h00 : bcnt_reg + 5'h01;
            if (bcnt_reg == BYTE_LAST) begin
              phase_reg <= P_EXEC;
            end
          end
          P_EXEC: begin
            mem_we_reg <= (cmd_reg == CMD_WRITE_MEM);
            mem_re_reg <= (cmd_reg == CMD_READ_MEM);
            tx_sr_reg <= status;
            phase_reg <= cmd_fmt.addr && cmd_fmt.rdata ? P_READ :
              (cmd_fmt.rdata ? P_SEND : P_CMD);
          end
          P_READ: begin
            tx_sr_reg <= mem_rdata;
            phase_reg <= P_SEND;
          end
          P_SEND: if (tx_done) begin
            tx_sr_reg <= {tx_sr_reg[6:0], 1'b0};
            bcnt_reg <= (bcnt_reg == BYTE_LAST) ? 5'h00 : bcnt_reg + 5'h01;
            if (bcnt_reg == BYTE_LAST) begin
              phase_reg <= P_CMD;
            end
          end
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.dev_oe = dev_oe_reg;
  assign link.dev_out = dev_out_reg;
  assign mem_addr = addr_reg;
  assign mem_wdata = wdata_reg;
  assign mem_we = mem_we_reg;
  assign mem_re = mem_re_reg;
  assign debug_ctrl = ctrl_reg;
  assign bdm_active = bdm_reg;
  assign chip_reset_n = chip_reset_n_reg;
endmodule // swdp_target

/* swdp_pod.sv */
`timescale 1ns/1ps
module swdp_pod import swdp_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Debug link
  swdp_link_if.host link,
  // Command request
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic sync_start,
  input wire logic target_reset_req,
  // Answers
  output logic busy,
  output logic rdata_valid,
  output logic [7:0] rdata,
  output logic sync_valid,
  output logic [11:0] sync_len
);

  typedef enum {H_IDLE, H_TX, H_RX, H_SYNC_LOW, H_SYNC_WAIT, H_SYNC_MEAS} swdp_host_t;

  logic [2:0] div_reg;
  logic tick_reg;
  logic pin_s1, pin_s2, pin_d;
  swdp_host_t hst_reg;
  logic [7:0] tcnt_reg, rd_sr_reg, rdata_reg;
  logic [31:0] sr_reg;
  logic [5:0] nbits_reg;
  logic rd_pend_reg, busy_reg, rdata_valid_reg, sync_valid_reg;
  logic [11:0] mcnt_reg, sync_len_reg;
  logic oe_reg, out_reg, rst_oe_reg;
  logic [7:0] low_len;
  logic bit_end;
  swdp_fmt_t cfmt;

  // ----------------------------------------------------------------
  // Bit clock and pin synchroniser
  // ----------------------------------------------------------------
  // host rate known from target clock
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= 3'h0;
      tick_reg <= 1'b0;
    // Restart at each take so the first bit of a frame is full length
    end else if (hst_reg == H_IDLE) begin
      div_reg <= 3'h0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (div_reg == DIV_LAST);
      div_reg <= div_reg + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_d <= 1'b1;
    end else begin
      pin_s1 <= link.debug_pin;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  assign cfmt = swdp_cmd_fmt(cmd_code);
  assign bit_end = tick_reg && (tcnt_reg == T_HOST_BIT - 8'h01);
  assign low_len = sr_reg[31] ? T_ONE_LOW : T_ZERO_LOW;

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hst_reg <= H_IDLE;
      tcnt_reg <= 8'h00;
      sr_reg <= 32'h0000_0000;
      nbits_reg <= 6'h00;
      rd_pend_reg <= 1'b0;
      rd_sr_reg <= 8'h00;
      rdata_reg <= 8'h00;
      busy_reg <= 1'b0;
      rdata_valid_reg <= 1'b0;
      sync_valid_reg <= 1'b0;
      mcnt_reg <= 12'h000;
      sync_len_reg <= 12'h000;
    end else begin
      rdata_valid_reg <= 1'b0;
      sync_valid_reg <= 1'b0;
      unique case (hst_reg)
        H_IDLE: begin
          tcnt_reg <= 8'h00;
          if (sync_start) begin
            busy_reg <= 1'b1;
            hst_reg <= H_SYNC_LOW;
          end else if (cmd_valid) begin
            busy_reg <= 1'b1;
            rd_pend_reg <= cfmt.rdata;
            sr_reg <= {cmd_code, cfmt.addr ? cmd_addr : {cmd_wdata, 8'h00},
              cfmt.addr ? cmd_wdata : 8'h00};
            nbits_reg <= BITS_BYTE + (cfmt.addr ? BITS_ADDR : 6'h00) +
              (cfmt.wdata ? BITS_BYTE : 6'h00);
            hst_reg <= H_TX;
          end
        end
        H_TX: if (bit_end) begin
          tcnt_reg <= 8'h00;
          sr_reg <= {sr_reg[30:0], 1'b0};
          nbits_reg <= (nbits_reg == 6'h01) ? BITS_BYTE : nbits_reg - 6'h01;
          if (nbits_reg == 6'h01) begin
            hst_reg <= rd_pend_reg ? H_RX : H_IDLE;
            busy_reg <= rd_pend_reg;
          end
        end else if (tick_reg) begin
          tcnt_reg <= tcnt_reg + 8'h01;
        end
        H_RX: if (tick_reg) begin
          tcnt_reg <= bit_end ? 8'h00 : tcnt_reg + 8'h01;
          if (tcnt_reg == T_SAMPLE) begin
            rd_sr_reg <= {rd_sr_reg[6:0], pin_s2};
          end
          if (bit_end) begin
            nbits_reg <= nbits_reg - 6'h01;
            if (nbits_reg == 6'h01) begin
              rdata_reg <= rd_sr_reg;
              rdata_valid_reg <= 1'b1;
              busy_reg <= 1'b0;
              hst_reg <= H_IDLE;
            end
          end
        end
        H_SYNC_LOW: if (tick_reg) begin
          tcnt_reg <= (tcnt_reg == T_SYNC_REQ - 8'h01) ? 8'h00 : tcnt_reg + 8'h01;
          if (tcnt_reg == T_SYNC_REQ - 8'h01) begin
            hst_reg <= H_SYNC_WAIT;
          end
        end
        // Give up if the target never answers
        H_SYNC_WAIT: if (pin_d && !pin_s2) begin
          mcnt_reg <= 12'h000;
          hst_reg <= H_SYNC_MEAS;
        end else if (tick_reg) begin
          tcnt_reg <= tcnt_reg + 8'h01;
          if (tcnt_reg == T_SYNC_TMO) begin
            sync_len_reg <= 12'h000;
            sync_valid_reg <= 1'b1;
            busy_reg <= 1'b0;
            hst_reg <= H_IDLE;
          end
        end
        H_SYNC_MEAS: if (pin_s2) begin
          sync_len_reg <= mcnt_reg;
          sync_valid_reg <= 1'b1;
          busy_reg <= 1'b0;
          hst_reg <= H_IDLE;
        end else if (mcnt_reg != MEAS_MAX) begin
          mcnt_reg <= mcnt_reg + 12'h001;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      oe_reg <= 1'b0;
      out_reg <= 1'b1;
      rst_oe_reg <= 1'b0;
    end else begin
      rst_oe_reg <= target_reset_req;
      oe_reg <= 1'b0;
      out_reg <= 1'b1;
      unique case (hst_reg)
        H_TX: begin
          oe_reg <= (tcnt_reg <= low_len);
          out_reg <= (tcnt_reg == low_len);
        end
        // Target owns the pin after release, so no speedup here
        H_RX: begin
          oe_reg <= (tcnt_reg < T_ONE_LOW);
          out_reg <= 1'b0;
        end
        H_SYNC_LOW: begin
          oe_reg <= 1'b1;
          out_reg <= 1'b0;
        end
        H_IDLE, H_SYNC_WAIT, H_SYNC_MEAS: oe_reg <= 1'b0;
      endcase
    end
  end

  assign link.host_oe = oe_reg;
  assign link.host_out = out_reg;
  assign link.rst_oe = rst_oe_reg;
  assign busy = busy_reg;
  assign rdata_valid = rdata_valid_reg;
  assign rdata = rdata_reg;
  assign sync_valid = sync_valid_reg;
  assign sync_len = sync_len_reg;

endmodule // swdp_pod

/* swdp_link_properties.sv */
`timescale 1ns/1ps
module swdp_link_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Link signals
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic rst_oe,
  input wire logic debug_pin,
  input wire logic reset_n
);
  // ----
  // Run-length counters
  // ----
  logic hl, hh, dl, dh;
  logic [11:0] hl_cnt_reg, dl_cnt_reg, gap_reg, per_reg;
  assign hl = host_oe & ~host_out;
  assign hh = host_oe & host_out;
  assign dl = dev_oe & ~dev_out;
  assign dh = dev_oe & dev_out;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Gap and period counters saturate so a long idle never wraps into a false short gap
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hl_cnt_reg <= 12'h000;
      dl_cnt_reg <= 12'h000;
      gap_reg <= 12'hfff;
      per_reg <= 12'hfff;
    end else begin
      hl_cnt_reg <= hl ? hl_cnt_reg + 12'h001 : 12'h000;
      dl_cnt_reg <= dl ? dl_cnt_reg + 12'h001 : 12'h000;
      gap_reg <= hl ? 12'h000 : (&gap_reg ? gap_reg : gap_reg + 12'h001);
      per_reg <= (hl && hl_cnt_reg == 12'h000) ? 12'h000
        : (&per_reg ? per_reg : per_reg + 12'h001);
    end
  end
  // ----
  // Assertions
  // ----
  chk_no_drive_clash: assert property (!(host_oe && dev_oe))
    else $error("both ends drive the pin");
  chk_idle_pullup: assert property (!host_oe && !dev_oe |-> debug_pin)
    else $error("released pin not high");
  chk_host_speedup: assert property ($rose(hh) |-> ##[1:9] !hh)
    else $error("host high drive too long");
  chk_dev_speedup: assert property ($rose(dh) |-> ##[1:9] !dh)
    else $error("target high drive too long");
  chk_dev_no_start: assert property ($rose(dev_oe) |-> gap_reg < 12'd400)
    else $error("target drove without host bit");
  chk_sync_pulse_len: assert property ($fell(dl) |->
    (dl_cnt_reg <= 12'd120 || dl_cnt_reg inside {[12'd1000:12'd1048]}))
    else $error("target low pulse length wrong");
  chk_host_low_len: assert property ($fell(hl) |->
    hl_cnt_reg inside {[12'd28:12'd36], [12'd100:12'd108], [12'd1016:12'd1032]})
    else $error("host low time wrong");
  chk_bit_period: assert property (hl && hl_cnt_reg == 12'h000 |-> per_reg >= 12'd156)
    else $error("host bits too close");
  chk_reset_pull: assert property (rst_oe |-> !reset_n)
    else $error("reset line not pulled low");
  cover property ($fell(dl) && dl_cnt_reg > 12'd1000);
  cover property ($rose(dh));
  cover property ($rose(rst_oe));
endmodule // swdp_link_properties

/* testbench.sv */
`timescale 1ns/1ps
module testbench import swdp_pkg::*;;
  logic ref_clk, resetn, cmd_valid, sync_start, rst_req;
  logic [7:0] cmd_code, cmd_wdata, mem_rdata, rdata, debug_ctrl, mem_wdata, exp_wd, d;
  logic [15:0] cmd_addr, mem_addr, exp_wa, a;
  logic mem_we, mem_re, bdm_active, chip_reset_n, busy, rdata_valid, sync_valid;
  logic [11:0] sync_len;
  int fail_count = 0, comparisons = 0, we_cnt = 0, n = 0, seed = 32'h20d7;
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  swdp_link_if swdp_link_if_i ();
  swdp_target swdp_target_i (.ref_clk(ref_clk), .resetn(resetn), .link(swdp_link_if_i),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
    .mem_rdata(mem_rdata), .debug_ctrl(debug_ctrl), .bdm_active(bdm_active),
    .chip_reset_n(chip_reset_n));
  swdp_pod swdp_pod_i (.ref_clk(ref_clk), .resetn(resetn), .link(swdp_link_if_i),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .sync_start(sync_start), .target_reset_req(rst_req), .busy(busy),
    .rdata_valid(rdata_valid), .rdata(rdata), .sync_valid(sync_valid), .sync_len(sync_len));
  swdp_link_properties swdp_link_properties_i (.ref_clk(ref_clk), .resetn(resetn),
    .host_out(swdp_link_if_i.host_out), .host_oe(swdp_link_if_i.host_oe),
    .dev_out(swdp_link_if_i.dev_out), .dev_oe(swdp_link_if_i.dev_oe),
    .rst_oe(swdp_link_if_i.rst_oe), .debug_pin(swdp_link_if_i.debug_pin),
    .reset_n(swdp_link_if_i.reset_n));
  // ----
  // Helpers
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Memory contents are a pure function of the address, so no storage is needed
  function automatic logic [7:0] mem_of(input logic [15:0] ad);
    return ad[15:8] ^ ad[7:0] ^ 8'h5a;
  endfunction
  always @(negedge ref_clk) begin
    if (mem_re === 1'b1) begin
      mem_rdata <= mem_of(mem_addr);
    end
    if (mem_we === 1'b1) begin
      we_cnt++;
      chk(mem_addr, exp_wa);
      chk({8'h00, mem_wdata}, {8'h00, exp_wd});
    end
  end
  // No queue in the pod: the request is held only for the taking edge
  task automatic send(input logic [7:0] c, input logic [15:0] ad, input logic [7:0] dt);
    int k;
    k = 0;
    cmd_code = c;
    cmd_addr = ad;
    cmd_wdata = dt;
    exp_wa = ad;
    exp_wd = dt;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    @(negedge ref_clk);
    while (busy !== 1'b0 && k < 6000) begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= 6000) fail_count++;
    repeat (4) @(negedge ref_clk);
  endtask
  initial begin
    #780000;
    fail_count++;
    give_verdict();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    {cmd_valid, sync_start, rst_req, resetn} = 4'h0;
    {cmd_code, cmd_wdata, mem_rdata, exp_wd} = 32'h00000000;
    {cmd_addr, exp_wa} = 32'h00000000;
    repeat (20) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk({15'h0000, chip_reset_n}, 16'h0001);
    chk({15'h0000, bdm_active}, 16'h0000);
    sync_start = 1'b1;
    @(negedge ref_clk);
    sync_start = 1'b0;
    while (sync_valid !== 1'b1 && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    chk({15'h0000, sync_len inside {[12'd1000:12'd1048]}}, 16'h0001);
    repeat (40) @(negedge ref_clk);
    d = 8'($random(seed));
    send(CMD_WRITE_CONTROL, 16'h0000, d);
    chk({8'h00, debug_ctrl}, {8'h00, d});
    send(CMD_READ_STATUS, 16'h0000, 8'h00);
    chk({8'h00, rdata}, {8'h00, 2'b00, d[5:0]});
    send(CMD_BACKGROUND, 16'h0000, 8'h00);
    chk({15'h0000, bdm_active}, 16'h0001);
    send(CMD_READ_STATUS, 16'h0000, 8'h00);
    chk({8'h00, rdata}, {8'h00, 2'b10, d[5:0]});
    for (int i = 0; i < 5; i++) begin
      a = (i == 0) ? 16'hffff : ((i == 1) ? 16'h0000 : 16'($random(seed)));
      exp_wd = (i == 0) ? 8'h80 : ((i == 1) ? 8'h01 : 8'($random(seed)));
      send(CMD_WRITE_MEM, a, exp_wd);
      send(CMD_READ_MEM, a, 8'h00);
      chk({8'h00, rdata}, {8'h00, mem_of(a)});
      chk({15'h0000, bdm_active}, 16'h0001);
    end
    send(8'hff, 16'h1234, 8'h3c);
    chk({8'h00, debug_ctrl}, {8'h00, d});
    chk(16'(we_cnt), 16'h0005);
    send(CMD_GO, 16'h0000, 8'h00);
    chk({15'h0000, bdm_active}, 16'h0000);
    rst_req = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk({15'h0000, chip_reset_n}, 16'h0000);
    rst_req = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk({14'h0000, chip_reset_n, bdm_active}, 16'h0002);
    // Reset pulled during a sync low straps the target into debug mode
    sync_start = 1'b1;
    @(negedge ref_clk);
    {sync_start, rst_req} = 2'b01;
    repeat (8) @(negedge ref_clk);
    rst_req = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk({14'h0000, chip_reset_n, bdm_active}, 16'h0003);
    n = 0;
    while (sync_valid !== 1'b1 && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    chk({15'h0000, sync_len inside {[12'h3e8:12'h418]}}, 16'h0001);
    give_verdict();
  end
endmodule // testbench
